// ---- src/peepc_pkg.sv ----
`default_nettype none
package peepc_pkg;
	// ----------------------------------------------------------------
	// Register word indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_CFG    = 6'h11;
	localparam logic [5:0] IDX_STATUS = 6'h12;
	localparam logic [5:0] IDX_PAGE   = 6'h13;
	localparam logic [5:0] IDX_FC     = 6'h14;
	localparam logic [5:0] IDX_RX     = 6'h15;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int         EN_W         = 8;
	localparam int         PEND_LSB     = 8;
	localparam int         PEND_MSB     = 15;
	localparam int         PAGE_W       = 3;
	localparam int         CFG_W        = 3;
	localparam int         CFG_FSEL_BIT = 2;
	localparam int         CNT_W        = 8;
	localparam logic [7:0] EN_RESET     = 8'h00;
	localparam logic [2:0] CFG_RESET    = 3'h0;
	localparam logic [15:0] HALF_ZERO   = 16'h0000;

	// ----------------------------------------------------------------
	// Bus constants
	// ----------------------------------------------------------------
	localparam logic [2:0] SIZE_WORD = 3'h2;
	localparam logic       RESP_OKAY = 1'b0;

	// Register banks selected by the page field
	typedef enum logic [2:0] {
		PAGE_EXT     = 3'h0,
		PAGE_DIAG    = 3'h2,
		PAGE_TP_BASE = 3'h4,
		PAGE_TP_CFG5 = 3'h5,
		PAGE_TP_CFG6 = 3'h6
	} peepc_page_t;
endpackage : peepc_pkg
`default_nettype wire

// ---- src/peepc_regs.sv ----
`default_nettype none

// --------------------------------------------------------------------
// Saturating event counter with clear
// --------------------------------------------------------------------
module peepc_sat_counter #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// Control
	input  wire logic         inc,
	input  wire logic         clr,
	// State
	output logic [W-1:0]      count,
	output logic              half
);
	localparam logic [W-1:0] ONE      = W'(1);
	localparam logic [W-1:0] BELOW_HF = {1'b0, {(W-1){1'b1}}};

	// Clear and count; an event in the clearing cycle counts as one
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= '0;
		end else if (inc && clr) begin
			count <= ONE;
		end else if (inc && !(&count)) begin
			count <= W'(count + ONE);
		end else if (clr) begin
			count <= '0;
		end
	end

	// Most significant bit about to rise
	assign half = inc && !clr && (count == BELOW_HF);
endmodule : peepc_sat_counter

// --------------------------------------------------------------------
// Event enables, page selector and error tallies
// --------------------------------------------------------------------
module peepc_regs #(
	parameter int AW = 8
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          arst_n,
	// AHB-Lite slave
	input  wire logic          hsel,
	input  wire logic [AW-1:0] haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic          hready,
	input  wire logic [31:0]   hwdata,
	output logic               hreadyout,
	output logic               hresp,
	output logic [31:0]        hrdata,
	// Status events, one-cycle pulses
	input  wire logic          quality_evt,
	input  wire logic          energy_evt,
	input  wire logic          link_change_evt,
	input  wire logic          speed_change_evt,
	input  wire logic          duplex_change_evt,
	input  wire logic          time_protocol_evt,
	input  wire logic          autoneg_done_evt,
	input  wire logic          control_frame_evt,
	input  wire logic          false_carrier_evt,
	// Receive line condition
	input  wire logic          carrier_valid,
	input  wire logic          invalid_symbol,
	input  wire logic          collision,
	// Device outputs
	output logic               irq,
	output logic [2:0]         page,
	output logic               page_reserved
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic                  addr_ok;
	logic                  rd_req;
	logic [5:0]            idx;
	logic                  wr_pend;
	logic [5:0]            wr_idx;
	logic [7:0]            enables;
	logic [7:0]            next_enables;
	logic [2:0]            next_page;
	logic [2:0]            cfg;
	logic [2:0]            next_cfg;
	logic [7:0]            pending;
	logic [7:0]            next_pending;
	logic [7:0]            ev;
	logic                  ctr_mode;
	logic                  fsel;
	logic                  page_ext;
	logic                  rd_clr_st;
	logic                  rd_clr_fc;
	logic                  rd_clr_rx;
	logic [7:0]            fc_cnt;
	logic [7:0]            rx_cnt;
	logic                  fc_half;
	logic                  rx_half;
	logic                  carrier_q;
	logic                  err_seen;
	logic                  coll_seen;
	logic                  rx_inc;
	logic [15:0]           rd_val;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Only whole-word transfers are taken; others read zero
	assign addr_ok   = hsel && htrans[1] && hready && (hsize == peepc_pkg::SIZE_WORD);
	assign rd_req    = addr_ok && !hwrite;
	assign idx       = 6'(haddr[AW-1:2]);
	assign hreadyout = 1'b1;
	assign hresp     = peepc_pkg::RESP_OKAY;

	// Write address held into the data phase
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_pend <= 1'b0;
			wr_idx  <= 6'h00;
		end else begin
			wr_pend <= addr_ok && hwrite;
			wr_idx  <= idx;
		end
	end

	// ----------------------------------------------------------------
	// Writable registers; next values also forward to reads
	// ----------------------------------------------------------------
	// Only the writable low bits are taken, the rest dropped
	always_comb begin
		next_enables = enables;
		next_page    = page;
		next_cfg     = cfg;
		if (wr_pend && wr_idx == peepc_pkg::IDX_STATUS) begin
			next_enables = hwdata[peepc_pkg::EN_W-1:0];
		end
		if (wr_pend && wr_idx == peepc_pkg::IDX_PAGE) begin
			next_page = hwdata[peepc_pkg::PAGE_W-1:0];
		end
		if (wr_pend && wr_idx == peepc_pkg::IDX_CFG) begin
			next_cfg = hwdata[peepc_pkg::CFG_W-1:0];
		end
	end

	// Enable bits
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			enables <= peepc_pkg::EN_RESET;
		end else begin
			enables <= next_enables;
		end
	end

	// Page selector, zero after reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			page <= peepc_pkg::PAGE_EXT;
		end else begin
			page <= next_page;
		end
	end

	// Counter select and interrupt-function select
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg <= peepc_pkg::CFG_RESET;
		end else begin
			cfg <= next_cfg;
		end
	end

	// Bank decode for the upper addresses
	always_comb begin
		unique case (page)
			peepc_pkg::PAGE_EXT, peepc_pkg::PAGE_DIAG, peepc_pkg::PAGE_TP_BASE,
			peepc_pkg::PAGE_TP_CFG5, peepc_pkg::PAGE_TP_CFG6: begin
				page_reserved = 1'b0;
			end
			default: begin
				page_reserved = 1'b1;
			end
		endcase
	end

	assign ctr_mode = |cfg[peepc_pkg::CFG_FSEL_BIT-1:0];
	assign fsel     = cfg[peepc_pkg::CFG_FSEL_BIT];
	assign page_ext = (next_page == peepc_pkg::PAGE_EXT);

	// ----------------------------------------------------------------
	// Read side effects
	// ----------------------------------------------------------------
	// Counters clear only when their bank is mapped
	assign rd_clr_st = rd_req && idx == peepc_pkg::IDX_STATUS;
	assign rd_clr_fc = rd_req && idx == peepc_pkg::IDX_FC && page_ext;
	assign rd_clr_rx = rd_req && idx == peepc_pkg::IDX_RX && page_ext;

	// ----------------------------------------------------------------
	// Tallies
	// ----------------------------------------------------------------
	// Tracks one carrier event for bad symbols and collisions
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			carrier_q <= 1'b0;
			err_seen  <= 1'b0;
			coll_seen <= 1'b0;
		end else begin
			carrier_q <= carrier_valid;
			err_seen  <= carrier_valid && (err_seen || invalid_symbol);
			coll_seen <= carrier_valid && (coll_seen || collision);
		end
	end

	// Counted once, when the carrier event closes
	assign rx_inc = carrier_q && !carrier_valid && err_seen && !coll_seen;

	peepc_sat_counter #(
		.W      (peepc_pkg::CNT_W)
	) u_fc_tally (
		.clk    (clk),
		.arst_n (arst_n),
		.inc    (false_carrier_evt),
		.clr    (rd_clr_fc),
		.count  (fc_cnt),
		.half   (fc_half)
	);

	peepc_sat_counter #(
		.W      (peepc_pkg::CNT_W)
	) u_rx_tally (
		.clk    (clk),
		.arst_n (arst_n),
		.inc    (rx_inc),
		.clr    (rd_clr_rx),
		.count  (rx_cnt),
		.half   (rx_half)
	);

	// ----------------------------------------------------------------
	// Pending interrupts
	// ----------------------------------------------------------------
	// Events aligned with enable bits 7..0
	always_comb begin
		ev[7] = quality_evt;
		ev[6] = energy_evt;
		ev[5] = link_change_evt;
		ev[4] = fsel ? (speed_change_evt || duplex_change_evt) : speed_change_evt;
		ev[3] = fsel ? time_protocol_evt : duplex_change_evt;
		ev[2] = autoneg_done_evt;
		ev[1] = ctr_mode ? (fc_half || rx_half) : fc_half;
		ev[0] = ctr_mode ? control_frame_evt : rx_half;
	end

	// Status read clears; a same-cycle event still lands
	assign next_pending = (pending & ~{8{rd_clr_st}}) | (ev & enables);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pending <= 8'h00;
		end else begin
			pending <= next_pending;
		end
	end

	// Interrupt output
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_pending & next_enables);
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Unmapped, reserved and paged-out words read zero
	always_comb begin
		rd_val = peepc_pkg::HALF_ZERO;
		unique case (idx)
			peepc_pkg::IDX_STATUS: begin
				rd_val = {pending, next_enables};
			end
			peepc_pkg::IDX_PAGE: begin
				rd_val[peepc_pkg::PAGE_W-1:0] = next_page;
			end
			peepc_pkg::IDX_CFG: begin
				rd_val[peepc_pkg::CFG_W-1:0] = next_cfg;
			end
			peepc_pkg::IDX_FC: begin
				if (page_ext) begin
					rd_val[peepc_pkg::CNT_W-1:0] = fc_cnt;
				end
			end
			peepc_pkg::IDX_RX: begin
				if (page_ext) begin
					rd_val[peepc_pkg::CNT_W-1:0] = rx_cnt;
				end
			end
			default: begin
				rd_val = peepc_pkg::HALF_ZERO;
			end
		endcase
	end

	// Data phase output
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hrdata <= 32'h0000_0000;
		end else begin
			hrdata <= rd_req ? {peepc_pkg::HALF_ZERO, rd_val} : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	st_read_clear_a: assert property (rd_clr_st && ev == 8'h00 |=> pending == 8'h00)
		else $error("status read did not clear pending bits");
	ctrl_frame_a: assert property (ctr_mode && control_frame_evt && enables[0]
		|=> pending[0])
		else $error("control frame event not pending");
	quality_gate_a: assert property (!enables[7] && !pending[7] |=> !pending[7])
		else $error("disabled quality event became pending");
	fc_count_a: assert property (false_carrier_evt && !rd_clr_fc && fc_cnt != 8'hff
		|=> fc_cnt == 8'($past(fc_cnt) + 8'h01))
		else $error("false carrier tally did not count");
	fc_sat_a: assert property (fc_cnt == 8'hff && !rd_clr_fc |=> fc_cnt == 8'hff)
		else $error("false carrier tally left saturation");
	rx_once_a: assert property ($past(carrier_valid) && !$past(rd_clr_rx)
		|-> $stable(rx_cnt))
		else $error("rx error tally moved inside carrier");
	rx_coll_a: assert property (carrier_q && !carrier_valid && coll_seen && !rd_clr_rx
		|=> $stable(rx_cnt))
		else $error("rx error tally counted a collision");
	rx_clear_a: assert property (rd_clr_rx && !rx_inc
		|=> rx_cnt == 8'h00 ##1 (rx_cnt == 8'h00 || $past(rx_inc)))
		else $error("rx error tally not cleared by read");
	page_write_a: assert property (wr_pend && wr_idx == peepc_pkg::IDX_PAGE
		|=> page == $past(hwdata[2:0]))
		else $error("page write not taken");
	page_resv_a: assert property (rd_req && idx == peepc_pkg::IDX_PAGE
		|=> hrdata[31:3] == 29'h0000_0000)
		else $error("page reserved bits not zero");
	half_event_a: assert property (!ctr_mode && fc_cnt == 8'h7f && false_carrier_evt
		&& !rd_clr_fc && enables[1] |=> pending[1] && fc_cnt[7])
		else $error("half-full event not flagged");
	irq_level_a: assert property (irq == |(pending & enables))
		else $error("interrupt output disagrees with pending bits");

	rx_count_c: cover property (rx_inc ##1 rx_cnt != 8'h00);
	fc_sat_c: cover property (fc_cnt == 8'hff && false_carrier_evt);
	irq_clear_c: cover property (irq ##1 rd_clr_st ##1 !irq);
	ctr_mode_c: cover property (ctr_mode && rx_half && enables[1]);
endmodule : peepc_regs
`default_nettype wire

// ---- src/peepc_dummy_unused.sv ----
`default_nettype none
`default_nettype wire

// ---- bench/peepc_host.sv ----
`default_nettype none
// ----------------------------------------------------------------
// Management host: single-word AHB-Lite master
// ----------------------------------------------------------------
module peepc_host (
	// Clock
	input  wire logic        clk,
	// Slave answer
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	// Request
	output logic             hsel,
	output logic [7:0]       haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus from time zero
	initial begin
		hsel   = 1'b0;
		haddr  = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0000_0000;
	end
	// One transfer; each phase is held until hready is seen high
	task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= {idx, 2'b00};
		htrans <= 2'h2;
		hwrite <= w;
		hsize  <= peepc_pkg::SIZE_WORD;
		do @(posedge clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		haddr  <= ~haddr;                // Released address shows a changing pattern
		hwdata <= w ? wd : ~hwdata;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		hwdata <= ~hwdata;               // Released data line no longer holds the word
	endtask : xfer
endmodule : peepc_host
`default_nettype wire

// ---- bench/tb_top.sv ----
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Signals and reference model state
	// ------------------------------------------------------------
	logic        clk, arst_n, hsel, hwrite, hreadyout, hresp, irq, page_reserved;
	logic        carrier_valid, invalid_symbol, collision;
	logic [7:0]  haddr, m_pend, m_en;
	logic [1:0]  htrans;
	logic [2:0]  hsize, page, m_cfg, m_page;
	logic [31:0] hwdata, hrdata, rd;
	logic [8:0]  evt;
	int          n_mismatch, n_checks, m_fc, m_rx;

	// Host and block under test
	peepc_host host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	peepc_regs #(.AW(8)) dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.quality_evt(evt[7]), .energy_evt(evt[6]), .link_change_evt(evt[5]),
		.speed_change_evt(evt[4]), .duplex_change_evt(evt[3]), .time_protocol_evt(evt[8]),
		.autoneg_done_evt(evt[2]), .control_frame_evt(evt[0]), .false_carrier_evt(evt[1]),
		.carrier_valid(carrier_valid), .invalid_symbol(invalid_symbol),
		.collision(collision), .irq(irq), .page(page), .page_reserved(page_reserved));

	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#300us;
		n_mismatch++;
		end_of_test();
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		host.xfer(1'b1, idx, d, rd);
		if (idx == peepc_pkg::IDX_CFG) m_cfg = d[2:0];
		if (idx == peepc_pkg::IDX_STATUS) m_en = d[7:0];
		if (idx == peepc_pkg::IDX_PAGE) m_page = d[2:0];
	endtask : wr
	// Read one word and compare with the model, applying clear-on-read
	task automatic rdc(input logic [5:0] idx);
		logic [31:0] e;
		e = 32'h0000_0000;
		host.xfer(1'b0, idx, 32'h0000_0000, rd);
		case (idx)
			peepc_pkg::IDX_CFG: e[2:0] = m_cfg;
			peepc_pkg::IDX_STATUS: begin
				e[15:0] = {m_pend, m_en};
				m_pend = 8'h00;
			end
			peepc_pkg::IDX_PAGE: e[2:0] = m_page;
			peepc_pkg::IDX_FC: if (m_page == 3'h0) begin
				e = m_fc;
				m_fc = 0;
			end
			peepc_pkg::IDX_RX: if (m_page == 3'h0) begin
				e = m_rx;
				m_rx = 0;
			end
			default: e = 32'h0000_0000;
		endcase
		chk(rd, e, "read data");
		chk({31'h0, hresp}, 32'h0000_0000, "response");
	endtask : rdc
	// Saturating tally model with half-full event at 0x80
	task automatic bump(input logic fc);
		if (fc) begin
			if (m_fc < 255) m_fc++;
			if (m_fc == 128 && m_en[1]) m_pend[1] = 1'b1;
		end else begin
			if (m_rx < 255) m_rx++;
			if (m_rx == 128 && m_cfg[1:0] == 2'h0) m_pend[0] |= m_en[0];
			if (m_rx == 128 && m_cfg[1:0] != 2'h0) m_pend[1] |= m_en[1];
		end
	endtask : bump
	// One-cycle event pulse, then the interrupt level is compared
	task automatic pulse(input int k);
		@(posedge clk);
		evt[k] <= 1'b1;
		@(posedge clk);
		evt[k] <= 1'b0;
		if (k == 1) bump(1'b1);
		else if (k == 3 && m_cfg[2]) m_pend[4] |= m_en[4];
		else if (k >= 2 && k <= 7) m_pend[k] |= m_en[k];
		else if (k == 8 && m_cfg[2]) m_pend[3] |= m_en[3];
		else if (k == 0 && m_cfg[1:0] != 2'h0) m_pend[0] |= m_en[0];
		#1;
		chk({31'h0, irq}, {31'h0, |(m_pend & m_en)}, "interrupt");
	endtask : pulse
	// Carrier event lasting three cycles with two invalid symbols when bad
	task automatic frame(input logic bad, input logic col);
		@(posedge clk);
		carrier_valid <= 1'b1;
		collision     <= col;
		@(posedge clk);
		invalid_symbol <= bad;
		repeat (2) @(posedge clk);
		invalid_symbol <= 1'b0;
		carrier_valid  <= 1'b0;
		collision      <= 1'b0;
		repeat (2) @(posedge clk);
		if (bad && !col) bump(1'b0);
	endtask : frame
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		arst_n = 1'b0;
		evt = 9'h000;
		{carrier_valid, invalid_symbol, collision} = 3'b000;
		{n_mismatch, n_checks, m_fc, m_rx} = '0;
		{m_pend, m_en, m_cfg, m_page} = '0;
		void'($urandom(76933));
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		// Reset values, unmapped words and read-only words
		wr(peepc_pkg::IDX_FC, 32'hFFFF_FFFF);
		wr(peepc_pkg::IDX_RX, 32'hFFFF_FFFF);
		for (int i = 'h10; i <= 'h16; i++) rdc(6'(i));
		$display("test reset done");
		// Page field, reserved bits and reserved page values
		for (int p = 0; p < 8; p++) begin
			wr(peepc_pkg::IDX_PAGE, 32'hFFFF_FFF8 | p);
			rdc(peepc_pkg::IDX_PAGE);
			chk({29'h0, page}, p, "page");
			chk({31'h0, page_reserved}, (p == 1 || p == 3 || p == 7), "reserved");
		end
		wr(peepc_pkg::IDX_STATUS, 32'h0000_0002);
		repeat (5) pulse(1);
		rdc(peepc_pkg::IDX_FC);
		wr(peepc_pkg::IDX_PAGE, 32'h0000_0000);
		rdc(peepc_pkg::IDX_FC);
		$display("test page done");
		// Random enable patterns gate the plain events
		for (int r = 0; r < 6; r++) begin
			wr(peepc_pkg::IDX_STATUS, {$urandom} | 32'h0000_FF00);
			for (int k = 0; k < 9; k++) begin
				if (k != 1) pulse(k);
			end
			rdc(peepc_pkg::IDX_STATUS);
			rdc(peepc_pkg::IDX_STATUS);
		end
		// Alternate functions of bits 11 and 8
		wr(peepc_pkg::IDX_CFG, 32'h0000_0004);
		wr(peepc_pkg::IDX_STATUS, 32'h0000_0018);
		pulse(8);
		pulse(3);
		rdc(peepc_pkg::IDX_STATUS);
		for (int c = 1; c < 4; c++) begin
			wr(peepc_pkg::IDX_CFG, c);
			wr(peepc_pkg::IDX_STATUS, 32'h0000_0001);
			pulse(0);
			rdc(peepc_pkg::IDX_STATUS);
		end
		wr(peepc_pkg::IDX_CFG, 32'h0000_0000);
		$display("test functions done");
		// False carrier tally: half-full event and saturation
		wr(peepc_pkg::IDX_STATUS, 32'h0000_0002);
		repeat (128) pulse(1);
		rdc(peepc_pkg::IDX_STATUS);
		rdc(peepc_pkg::IDX_FC);
		repeat (255 + $urandom % 8) pulse(1);
		rdc(peepc_pkg::IDX_FC);
		rdc(peepc_pkg::IDX_FC);
		$display("test false carrier done");
		// Receive error tally: collisions, once per event, saturation
		wr(peepc_pkg::IDX_STATUS, 32'h0000_0001);
		repeat (24) frame(1'($urandom), 1'($urandom));
		rdc(peepc_pkg::IDX_RX);
		for (int f = 0; f < 260; f++) begin
			frame(1'b1, 1'b0);
			if (f == 127) rdc(peepc_pkg::IDX_STATUS);
		end
		chk({31'h0, irq}, 32'h0000_0000, "interrupt after clear");
		rdc(peepc_pkg::IDX_RX);
		// Counter-select mode: rx half-full lands on enable bit 1
		wr(peepc_pkg::IDX_CFG, 32'h0000_0001);
		wr(peepc_pkg::IDX_STATUS, 32'h0000_0002);
		repeat (128) frame(1'b1, 1'b0);
		chk({31'h0, irq}, {31'h0, |(m_pend & m_en)}, "interrupt");
		rdc(peepc_pkg::IDX_STATUS);
		wr(peepc_pkg::IDX_CFG, 32'h0000_0000);
		$display("test receive error done");
		// Reset in mid-run returns page and enables to zero
		wr(peepc_pkg::IDX_PAGE, 32'h0000_0005);
		@(posedge clk);
		arst_n <= 1'b0;
		@(posedge clk);
		arst_n <= 1'b1;
		{m_pend, m_en, m_cfg, m_page} = '0;
		{m_fc, m_rx} = '0;
		rdc(peepc_pkg::IDX_PAGE);
		rdc(peepc_pkg::IDX_STATUS);
		rdc(peepc_pkg::IDX_RX);
		$display("test second reset done");
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
